/* File: pkg/amx_pkg.sv */
// Purpose: shared constants and types of the eight-line serial mux block
// Assumes: 16-bit registers in the low half of the 32-bit apb data word
// Notes: register offsets are the low three bus address bits
package amx_pkg;
  // ==================================================================
  // address decode
  localparam int ADDR_W = 18;
  localparam logic [4:0] HIGH_PAGE = 5'h1F;
  localparam logic [2:0] OFS_CSR = 3'h0;
  localparam logic [2:0] OFS_RECEIVE_FIFO_OUTPUT_REGISTER = 3'h2;
  localparam logic [2:0] OFS_TCR = 3'h4;
  localparam logic [2:0] OFS_MSR = 3'h6;
  // ==================================================================
  // control-status field positions
  localparam int CSR_MAINT = 3;
  localparam int CSR_SCAN = 5;
  localparam int CSR_RIE = 6;
  localparam int CSR_SAE = 12;
  localparam int CSR_TIE = 14;
  localparam logic [15:0] CSR_RESET = 16'h0000;
  localparam logic [7:0] TCR_RESET = 8'h00;
  // ==================================================================
  // receive store
  localparam int FIFO_DEPTH = 64;
  localparam int ALARM_COUNT = 16;
  // ==================================================================
  // scanner timing
  localparam int SYS_KHZ = 40000;
  localparam int MASTER_KHZ = 5068;
  localparam logic [2:0] PHASE_DIV = 3'h5;
  localparam int SLOT_NS = 4000;
  localparam int SLOT_CYC = SLOT_NS * SYS_KHZ / 1000000;
  // ==================================================================
  // vectors
  localparam logic [8:0] VEC_TX_OFS = 9'h004;
  // ==================================================================
  // receive store entry
  typedef struct packed {
    logic [2:0] line;
    logic [7:0] data;
  } amx_rx_entry_t;
endpackage

/* File: src/amx_mux.sv */
// Purpose: bus side, scanner and receive store of an 8-line serial mux
// Assumes: per-line serializers and deserializers sit outside this block
// Notes: registers reached over apb; paddr is the 18-bit bus address
`timescale 1ns/1ps
module amx_mux
  import amx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int ALARM = ALARM_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration switches
  input wire logic [9:0] base_sw,
  input wire logic [5:0] vector_sw,
  // interrupt dialogue
  output logic receive_interrupt_request,
  output logic transmit_interrupt_request,
  input wire logic grant_in,
  output logic grant_out,
  output logic vec_valid,
  output logic [15:0] vec_data,
  // scanner
  output logic [2:0] line_select,
  // receive side of the line deserializers
  input wire logic [7:0] data_available_flag,
  input wire logic [7:0][7:0] rx_word,
  output logic [7:0] reset_data_available,
  // transmit side of the line serializers
  input wire logic [7:0] tx_buffer_empty,
  output logic [7:0] tx_load,
  output logic [7:0] tx_char,
  // serial streams
  input wire logic [7:0] tx_serial_in,
  output logic [7:0] line_tx_out,
  input wire logic [7:0] line_rx_in,
  output logic [7:0] deser_rx_in,
  // modem leads
  input wire logic [7:0] ring_indicate_input,
  input wire logic [7:0] carrier_input,
  output logic [7:0] dtr_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef enum logic [1:0] {PH1, PH2, PH3, PH4} amx_phase_t;

  logic [15:0] acc_ff;
  logic [2:0] div_ff;
  amx_phase_t phase_ff;
  logic [2:0] line_ff;
  logic master_tick;
  logic phase_tick;
  logic shi_ff;
  logic [7:0] rda_ff;
  logic maint_ff, scan_ff, rie_ff, sae_ff, tie_ff;
  logic sa_ff;
  logic [CW-1:0] alarm_cnt_ff;
  logic transmit_ready_flag_ff;
  logic [2:0] tline_ff;
  logic [7:0] line_en_ff, dtr_ff, break_ff;
  logic [7:0] tx_load_ff, tx_char_ff;
  amx_rx_entry_t mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff, rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic [15:0] out_ff;
  logic vec_valid_ff, grant_prev_ff, pop_ok_ff;
  logic hit, setup, access, wr_acc, rd_acc;
  logic fifo_full, fifo_empty, push, pop;
  logic rx_req, tx_req, vec_take;
  logic [15:0] rd_mux;
  logic [8:0] rx_vec;

  // ==================================================================
  // address decode and apb handshake
  assign hit = (paddr[17:13] == HIGH_PAGE)
             && (paddr[12:3] == base_sw)
             && !paddr[0];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_acc = access && hit && pwrite;
  assign rd_acc = access && hit && !pwrite;
  assign pready = access;
  assign pslverr = access && !hit;
  assign prdata = {16'h0000, out_ff};

  // ==================================================================
  // master clock, divider and phase generator
  // fractional accumulator stands in for the free-running master
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_ff <= 16'h0000;
    end else if (master_tick) begin
      acc_ff <= 16'(acc_ff + MASTER_KHZ - SYS_KHZ);
    end else begin
      acc_ff <= 16'(acc_ff + MASTER_KHZ);
    end
  end
  assign master_tick = (32'(acc_ff) + MASTER_KHZ) >= SYS_KHZ;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 3'h0;
    end else if (master_tick) begin
      div_ff <= (div_ff == PHASE_DIV - 3'h1) ? 3'h0 : div_ff + 3'h1;
    end
  end
  assign phase_tick = master_tick && (div_ff == PHASE_DIV - 3'h1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= PH1;
      line_ff <= 3'h0;
    end else if (phase_tick) begin
      phase_ff <= amx_phase_t'(phase_ff + 2'h1);
      if (phase_ff == PH4) begin
        line_ff <= line_ff + 3'h1;
      end
    end
  end
  assign line_select = line_ff;

  // ==================================================================
  // receive transfer: sample and store at the end of phase 1, reset data available at phase 2
  assign fifo_full = (count_ff == CW'(DEPTH));
  assign fifo_empty = (count_ff == '0);
  assign push = phase_tick && (phase_ff == PH1) && scan_ff
             && data_available_flag[line_ff] && !fifo_full;
  assign pop = rd_acc && (paddr[2:0] == OFS_RECEIVE_FIFO_OUTPUT_REGISTER) && pop_ok_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shi_ff <= 1'b0;
      rda_ff <= 8'h00;
    end else begin
      rda_ff <= 8'h00;
      if (push) begin
        shi_ff <= 1'b1;
      end else if (phase_tick && phase_ff == PH2) begin
        shi_ff <= 1'b0;
        if (shi_ff) begin
          rda_ff[line_ff] <= 1'b1;
        end
      end
    end
  end
  assign reset_data_available = rda_ff;

  // ==================================================================
  // receive store; a ring buffer behaves as a shift-down silo
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= '{line: line_ff, data: rx_word[line_ff]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= PW'(wr_ptr_ff + 1'b1);
      end
      if (pop) begin
        rd_ptr_ff <= PW'(rd_ptr_ff + 1'b1);
      end
      count_ff <= CW'(count_ff + push - pop);
    end
  end

  // alarm counts arrivals since the last buffer read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarm_cnt_ff <= '0;
      sa_ff <= 1'b0;
    end else begin
      if (rd_acc && paddr[2:0] == OFS_RECEIVE_FIFO_OUTPUT_REGISTER) begin
        alarm_cnt_ff <= CW'(push);
      end else if (push && alarm_cnt_ff != CW'(ALARM)) begin
        alarm_cnt_ff <= CW'(alarm_cnt_ff + 1'b1);
      end
      // a fresh alarm wins over the clearing read
      if (push && sae_ff && alarm_cnt_ff == CW'(ALARM - 1)) begin
        sa_ff <= 1'b1;
      end else if (rd_acc && paddr[2:0] == OFS_RECEIVE_FIFO_OUTPUT_REGISTER) begin
        sa_ff <= 1'b0;
      end
    end
  end

  // ==================================================================
  // control, line enable, dtr and break registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {tie_ff, sae_ff} <= {CSR_RESET[CSR_TIE], CSR_RESET[CSR_SAE]};
      {rie_ff, scan_ff, maint_ff} <= 3'b000;
      line_en_ff <= TCR_RESET;
      dtr_ff <= 8'h00;
      break_ff <= 8'h00;
    end else if (wr_acc) begin
      unique case (paddr[2:0])
        OFS_CSR: begin
          if (pstrb[0]) begin
            maint_ff <= pwdata[CSR_MAINT];
            scan_ff <= pwdata[CSR_SCAN];
            rie_ff <= pwdata[CSR_RIE];
          end
          if (pstrb[1]) begin
            sae_ff <= pwdata[CSR_SAE];
            tie_ff <= pwdata[CSR_TIE];
          end
        end
        OFS_TCR: begin
          if (pstrb[0]) begin
            line_en_ff <= pwdata[7:0];
          end
          if (pstrb[1]) begin
            dtr_ff <= pwdata[15:8];
          end
        end
        OFS_MSR: begin
          if (pstrb[1]) begin
            break_ff <= pwdata[15:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==================================================================
  // transmit scan and holding register
  // tline freezes while ready so the host loads the right line
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      transmit_ready_flag_ff <= 1'b0;
      tline_ff <= 3'h0;
      tx_load_ff <= 8'h00;
      tx_char_ff <= 8'h00;
    end else begin
      tx_load_ff <= 8'h00;
      if (transmit_ready_flag_ff && wr_acc && paddr[2:0] == OFS_MSR && pstrb[0]) begin
        tx_load_ff[tline_ff] <= 1'b1;
        tx_char_ff <= pwdata[7:0];
        transmit_ready_flag_ff <= 1'b0;
      end else if (!transmit_ready_flag_ff && phase_tick && phase_ff == PH1 && scan_ff
                   && line_en_ff[line_ff] && tx_buffer_empty[line_ff]) begin
        transmit_ready_flag_ff <= 1'b1;
        tline_ff <= line_ff;
      end
    end
  end
  assign tx_load = tx_load_ff;
  assign tx_char = tx_char_ff;

  // ==================================================================
  // serial paths and modem leads
  generate
    for (genvar i = 0; i < 8; i++) begin : g_line
      assign line_tx_out[i] = !break_ff[i] && tx_serial_in[i];
      assign deser_rx_in[i] = maint_ff ? tx_serial_in[i] : line_rx_in[i];
    end
  endgenerate
  assign dtr_out = dtr_ff;

  // ==================================================================
  // interrupts and shared output selector
  assign rx_req = rie_ff && (sae_ff ? sa_ff : !fifo_empty);
  assign tx_req = tie_ff && transmit_ready_flag_ff;
  assign receive_interrupt_request = rx_req;
  assign transmit_interrupt_request = tx_req;
  assign grant_out = grant_in && !rx_req && !tx_req;
  assign vec_take = grant_in && !grant_prev_ff && !psel && (rx_req || tx_req);
  assign rx_vec = {vector_sw, 3'b000};

  always_comb begin
    unique case (paddr[2:0])
      OFS_CSR: rd_mux = {transmit_ready_flag_ff, tie_ff, sa_ff, sae_ff, 1'b0, tline_ff,
                         !fifo_empty, rie_ff, scan_ff, 1'b0, maint_ff, 3'h0};
      OFS_RECEIVE_FIFO_OUTPUT_REGISTER: rd_mux = fifo_empty ? 16'h0000 :
                  {1'b1, 4'h0, mem[rd_ptr_ff].line, mem[rd_ptr_ff].data};
      OFS_TCR: rd_mux = {dtr_ff, line_en_ff};
      OFS_MSR: rd_mux = {carrier_input, ring_indicate_input};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_ff <= 16'h0000;
      vec_valid_ff <= 1'b0;
      grant_prev_ff <= 1'b0;
      pop_ok_ff <= 1'b0;
    end else begin
      grant_prev_ff <= grant_in;
      vec_valid_ff <= vec_take;
      if (setup) begin
        out_ff <= (hit && !pwrite) ? rd_mux : 16'h0000;
        // pop only what setup showed, else a late arrival is lost
        pop_ok_ff <= hit && !pwrite && paddr[2:0] == OFS_RECEIVE_FIFO_OUTPUT_REGISTER
                     && !fifo_empty;
      end else if (vec_take) begin
        out_ff <= {7'h00, rx_req ? rx_vec : rx_vec + VEC_TX_OFS};
      end
    end
  end
  assign vec_valid = vec_valid_ff;
  assign vec_data = out_ff;

  // ==================================================================
  // checks
  property p_store_bound;
    @(posedge clk) disable iff (!resetn) count_ff <= CW'(DEPTH);
  endproperty
  a_store_bound: assert property (p_store_bound)
    else $error("receive store over capacity");

  property p_read_advances;
    @(posedge clk) disable iff (!resetn)
      pop && !push |=> count_ff == $past(count_ff) - 1'b1;
  endproperty
  a_read_advances: assert property (p_read_advances)
    else $error("buffer read did not advance store");

  property p_fill_while_drain;
    @(posedge clk) disable iff (!resetn)
      pop && push |=> count_ff == $past(count_ff);
  endproperty
  a_fill_while_drain: assert property (p_fill_while_drain)
    else $error("arrival lost during read");

  property p_select;
    @(posedge clk) disable iff (!resetn)
      access && (paddr[17:13] != HIGH_PAGE || paddr[12:3] != base_sw)
      |-> pslverr;
  endproperty
  a_select: assert property (p_select)
    else $error("unselected address accepted");

  property p_tcr_read;
    @(posedge clk) disable iff (!resetn)
      setup && hit && !pwrite && paddr[2:0] == OFS_TCR
      |=> prdata[15:0] == $past({dtr_ff, line_en_ff});
  endproperty
  a_tcr_read: assert property (p_tcr_read)
    else $error("wrong register on read");

  property p_vector;
    @(posedge clk) disable iff (!resetn)
      vec_take |=> vec_valid && vec_data[8:0] ==
        ($past(rx_req) ? $past(rx_vec) : $past(rx_vec) + VEC_TX_OFS);
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong interrupt vector");

  property p_chain;
    @(posedge clk) disable iff (!resetn)
      (rx_req || tx_req) |-> !grant_out;
  endproperty
  a_chain: assert property (p_chain)
    else $error("grant passed on while requesting");

  property p_line_step;
    @(posedge clk) disable iff (!resetn)
      $changed(line_ff) |-> $past(div_ff) == PHASE_DIV - 3'h1
        && phase_ff == PH1 && line_ff == $past(line_ff) + 3'h1;
  endproperty
  a_line_step: assert property (p_line_step)
    else $error("line counter stepped off phase 1");

  property p_break;
    @(posedge clk) disable iff (!resetn)
      (break_ff != 8'h00) |-> (line_tx_out & break_ff) == 8'h00;
  endproperty
  a_break: assert property (p_break)
    else $error("break line not at space");

  property p_full_hold;
    @(posedge clk) disable iff (!resetn)
      fifo_full && !pop |=> count_ff == CW'(DEPTH);
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("push into full store");
endmodule

/* File: verification/amx_line_model.sv */
// Purpose: behavioural line side for the serial mux bus block
// Assumes: every line has a character waiting while da_on is high
// Notes: one shared sequence number tags each character handed over
`timescale 1ns/1ps
module amx_line_model
  import amx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bench controls
  input wire logic da_on,
  input wire logic refill,
  // block side
  input wire logic [7:0] reset_data_available,
  input wire logic [7:0] tx_load,
  output logic [7:0] data_available_flag,
  output logic [7:0][7:0] rx_word,
  output logic [7:0] tx_buffer_empty
);
  // ==================================================================
  // receive side
  logic [4:0] seq_ff;
  logic [7:0] full_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq_ff <= 5'h00;
    end else if (|reset_data_available) begin
      seq_ff <= seq_ff + 5'h01;
    end
  end
  // a fresh character is ready at once, so the flag stays up
  assign data_available_flag = {8{da_on}};
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // idle lines show an inverted pattern, not the last word
      rx_word[i] = da_on ? {3'(i), seq_ff} : ~{3'(i), seq_ff};
    end
  end
  // ==================================================================
  // transmit side: a loaded line stays busy until refilled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      full_ff <= 8'h00;
    end else if (refill) begin
      full_ff <= 8'h00;
    end else begin
      full_ff <= full_ff | tx_load;
    end
  end
  assign tx_buffer_empty = ~full_ff;
endmodule

/* File: verification/async_line_mux_bus_scanner_bench.sv */
// Purpose: self-checking bench of the mux bus side and scanner
// Assumes: line model answers every load and data reset
// Notes: expectations queue up; a monitor pops them as results appear
`timescale 1ns/1ps
module async_line_mux_bus_scanner_bench
  import amx_pkg::*;
;
  // ==================================================================
  // signals
  typedef struct packed {
    logic [32:0] v;
    logic [32:0] m;
  } amx_exp_t;
  localparam logic [9:0] BASE = 10'h001;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [5:0] vsw = 6'h00;
  logic grant_in = 1'b0, da_on = 1'b0, refill = 1'b0;
  logic [7:0] ring = 8'h00, car = 8'h00, txs = 8'h00, lrx = 8'h00;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rxq, txq, grant_out, vec_valid;
  logic [15:0] vec_data;
  logic [2:0] line_select;
  logic [7:0] dav, rda, tbe, tx_load, tx_char, ltx, drx, dtr_out;
  logic [7:0][7:0] rxw;
  amx_exp_t rq[$], vq[$], tq[$];
  int bad_count = 0, check_count = 0, cyc = 0;
  // ==================================================================
  // design and line model
  amx_mux #(.DEPTH(FIFO_DEPTH), .ALARM(ALARM_COUNT)) amx_mux_inst (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .base_sw(BASE), .vector_sw(vsw), .receive_interrupt_request(rxq),
    .transmit_interrupt_request(txq), .grant_in(grant_in),
    .grant_out(grant_out), .vec_valid(vec_valid), .vec_data(vec_data),
    .line_select(line_select), .data_available_flag(dav), .rx_word(rxw),
    .reset_data_available(rda), .tx_buffer_empty(tbe),
    .tx_load(tx_load), .tx_char(tx_char), .tx_serial_in(txs),
    .line_tx_out(ltx), .line_rx_in(lrx), .deser_rx_in(drx),
    .ring_indicate_input(ring), .carrier_input(car), .dtr_out(dtr_out));
  amx_line_model amx_line_model_inst (
    .clk(clk), .resetn(resetn), .da_on(da_on), .refill(refill),
    .reset_data_available(rda), .tx_load(tx_load),
    .data_available_flag(dav), .rx_word(rxw), .tx_buffer_empty(tbe));
  always #12.5 clk = ~clk;
  // ==================================================================
  // checking
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [32:0] g, input logic [32:0] e,
                     input logic [32:0] m);
    check_count++;
    if (((g ^ e) & m) !== 33'h0) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic pop(ref amx_exp_t q[$], input logic [32:0] g);
    amx_exp_t x;
    if (q.size() == 0) begin
      cmp(33'h1, 33'h0, ALL);
    end else begin
      x = q.pop_front();
      cmp(g, x.v, x.m);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      report_and_stop();
    end
    if (psel && penable && !pwrite && pready === 1'b1) begin
      pop(rq, {pslverr, prdata});
    end
    if (vec_valid === 1'b1) begin
      pop(vq, {17'h0, vec_data});
    end
    if (tx_load !== 8'h00) begin
      pop(tq, {17'h0, tx_load, tx_char});
    end
  end
  // ==================================================================
  // bus and grant drivers
  function automatic logic [17:0] ad(input logic [2:0] o);
    return {HIGH_PAGE, BASE, o};
  endfunction
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [3:0] s, input logic [15:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    if (!w) begin
      rq.push_back('{e, m});
    end
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pstrb <= s;
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the committing edge settle before callers sample outputs
    @(negedge clk);
  endtask
  task automatic grant(input logic [15:0] v);
    vq.push_back('{{17'h0, v}, ALL});
    @(posedge clk);
    grant_in <= 1'b1;
    repeat (2) @(posedge clk);
    cmp(grant_out, 1'b0, ALL);
    @(posedge clk);
    grant_in <= 1'b0;
  endtask
  task automatic poll_transmit_ready_flag();
    int n;
    n = 0;
    do begin
      apb(1'b0, ad(OFS_CSR), 4'h0, 16'h0, 33'h0, 33'h0);
      n++;
    end while (rdata[15] !== 1'b1 && n < 500);
  endtask
  task automatic slot_len(output int c);
    logic [2:0] s;
    s = line_select;
    c = 0;
    while (line_select === s && c < 400) begin
      @(posedge clk);
      c++;
    end
  endtask
  // ==================================================================
  // scenarios
  initial begin
    logic [2:0] tl;
    logic [7:0] ch, served;
    int c;
    void'($urandom(32'h0E74047D));
    vsw = 6'($urandom());
    ring = 8'($urandom());
    car = 8'($urandom());
    txs = 8'($urandom());
    lrx = ~txs;
    served = 8'h00;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, ad(OFS_CSR), 4'h0, 16'h0, 33'h0, ALL);
    apb(1'b0, ad(OFS_RECEIVE_FIFO_OUTPUT_REGISTER), 4'h0, 16'h0, 33'h0, ALL);
    apb(1'b0, ad(OFS_CSR) ^ 18'h02000, 4'h0, 16'h0, 33'h100000000, ALL);
    apb(1'b0, ad(OFS_CSR) ^ 18'h00008, 4'h0, 16'h0, 33'h100000000, ALL);
    apb(1'b1, ad(OFS_TCR), 4'h3, 16'hA508, 33'h0, 33'h0);
    apb(1'b0, ad(OFS_TCR), 4'h0, 16'h0, 33'h0A508, ALL);
    cmp(dtr_out, 8'hA5, ALL);
    apb(1'b1, ad(OFS_TCR), 4'h2, 16'h3C77, 33'h0, 33'h0);
    apb(1'b0, ad(OFS_TCR), 4'h0, 16'h0, 33'h03C08, ALL);
    apb(1'b0, ad(OFS_MSR), 4'h0, 16'h0, {17'h0, car, ring}, ALL);
    apb(1'b1, ad(OFS_MSR), 4'h2, 16'h5A00, 33'h0, 33'h0);
    cmp(ltx, txs & 8'hA5, ALL);
    apb(1'b1, ad(OFS_CSR), 4'h1, 16'h0008, 33'h0, 33'h0);
    cmp(drx, txs, ALL);
    apb(1'b1, ad(OFS_CSR), 4'h1, 16'h0000, 33'h0, 33'h0);
    cmp(drx, lrx, ALL);
    // every enabled line must get exactly one load
    apb(1'b1, ad(OFS_TCR), 4'h1, 16'h00FF, 33'h0, 33'h0);
    apb(1'b1, ad(OFS_CSR), 4'h3, 16'h4020, 33'h0, 33'h0);
    slot_len(c);
    tl = line_select;
    slot_len(c);
    cmp(line_select, 3'(tl + 3'h1), ALL);
    cmp(c >= SLOT_CYC - 6 && c <= SLOT_CYC + 2, 1'b1, ALL);
    for (int i = 0; i < 8; i++) begin
      poll_transmit_ready_flag();
      tl = rdata[10:8];
      if (i == 0) begin
        cmp(txq, 1'b1, ALL);
        grant({7'h0, vsw, 3'h0} + VEC_TX_OFS);
      end
      served[tl] = 1'b1;
      ch = 8'($urandom());
      tq.push_back('{{17'h0, 8'h01 << tl, ch}, ALL});
      apb(1'b1, ad(OFS_MSR), 4'h1, {8'h5A, ch}, 33'h0, 33'h0);
    end
    cmp(served, 8'hFF, ALL);
    // store fills while a transmit request also waits
    @(posedge clk);
    refill <= 1'b1;
    da_on <= 1'b1;
    @(posedge clk);
    refill <= 1'b0;
    apb(1'b1, ad(OFS_CSR), 4'h3, 16'h5060, 33'h0, 33'h0);
    repeat (70 * SLOT_CYC) @(posedge clk);
    apb(1'b0, ad(OFS_CSR), 4'h0, 16'h0, 33'h0A080, 33'h1FFFFA080);
    cmp(rxq, 1'b1, ALL);
    grant({7'h0, vsw, 3'h0});
    for (int k = 0; k < 65; k++) begin
      if (k == 64) begin
        repeat (2 * SLOT_CYC) @(posedge clk);
      end
      apb(1'b0, ad(OFS_RECEIVE_FIFO_OUTPUT_REGISTER), 4'h0, 16'h0, {25'h80, 3'h0, 5'(k)},
          33'h1FFFFF81F);
      cmp(rdata[10:8], rdata[7:5], ALL);
      // entry 64 follows idle slots spent full, so its line jumps
      if (k > 0 && k < 64) begin
        cmp(rdata[10:8], 3'(tl + 3'h1), ALL);
      end
      tl = rdata[10:8];
    end
    // reset in mid-run with characters still stored
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, ad(OFS_CSR), 4'h0, 16'h0, 33'h0, ALL);
    apb(1'b0, ad(OFS_RECEIVE_FIFO_OUTPUT_REGISTER), 4'h0, 16'h0, 33'h0, ALL);
    cmp({line_select, rxq, txq}, 5'h00, ALL);
    repeat (3) @(posedge clk);
    cmp(rq.size() + vq.size() + tq.size(), 33'h0, ALL);
    report_and_stop();
  end
endmodule
